/* File: hdl/bcs_core.sv */
// Purpose: Executes a subset of an 8-bit accumulator core's instructions
// Assumes: Software issues each instruction by a write to the INSTR word
// Notes:   Every bus access is answered at the second edge
`timescale 1ns/1ps
`default_nettype none
module bcs_core
    import bcs_pkg::*;
#(
    parameter int FILE_N = 32
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        wake_pin_i,
    output logic      [7:0]  dir_o,
    output logic             osc_run_o,
    output logic             asleep_o
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        ack_q;
    logic        req;
    logic        take_wr;
    logic [31:0] rdata_d;

    assign req           = read_i | write_i;
    assign waitrequest_o = req & ~ack_q;
    assign take_wr       = write_i & ack_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ----------------------------------------------------------------
    // Architectural state
    // ----------------------------------------------------------------
    logic [7:0] acc_q;
    logic [7:0] file_q [FILE_N];
    logic       c_q;
    logic       dc_q;
    logic       z_q;
    logic       to_n_q;
    logic       pwrdn_n_q;
    logic       wake_flag_q;
    bcs_pwr_e   pwr_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    bcs_op_e    op;
    logic       dbit;
    logic [4:0] fsel;
    logic [7:0] lit;
    logic       exec;
    logic [7:0] fval;
    logic       sw_wr_status;

    assign op   = bcs_op_e'(writedata_i[OP_MSB:OP_LSB]);
    assign dbit = writedata_i[D_BIT];
    assign fsel = writedata_i[F_MSB:0];
    assign lit  = writedata_i[LIT_MSB:0];
    assign fval = file_q[fsel];
    // Instructions are dropped while the oscillator is stopped
    assign exec = take_wr && (address_i == REG_INSTR) && (pwr_q == PS_RUN);
    assign sw_wr_status = take_wr && (address_i == REG_STATUS);

    logic [7:0] alu_res;
    logic       alu_c;
    logic       alu_dc;
    logic       alu_z;
    logic       upd_c;
    logic       upd_dc;
    logic       upd_z;
    logic       has_res;

    bcs_alu u_alu (
        .op_i      (op),
        .acc_i     (acc_q),
        .file_i    (fval),
        .lit_i     (lit),
        .c_i       (c_q),
        .res_o     (alu_res),
        .c_o       (alu_c),
        .dc_o      (alu_dc),
        .z_o       (alu_z),
        .upd_c_o   (upd_c),
        .upd_dc_o  (upd_dc),
        .upd_z_o   (upd_z),
        .has_res_o (has_res)
    );

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    logic       halt;
    logic [7:0] wdog_pre;
    logic [7:0] wdog_cnt;
    logic       wdog_to;

    assign halt = exec && (op == OP_SLEEP);

    bcs_wdog #(
        .PRE_W (8),
        .CNT_W (8)
    ) u_wdog (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clr_i     (halt),
        .pre_o     (wdog_pre),
        .cnt_o     (wdog_cnt),
        .timeout_o (wdog_to)
    );

    // ----------------------------------------------------------------
    // Wake pin, three-flop synchroniser
    // ----------------------------------------------------------------
    logic [2:0] wsync_q;
    logic       wfilt_q;
    logic       wake_evt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wsync_q <= 3'h0;
            wfilt_q <= 1'b0;
        end else begin
            wsync_q <= {wsync_q[1:0], wake_pin_i};
            if (wsync_q[1] == wsync_q[2]) begin
                wfilt_q <= wsync_q[2];
            end
        end
    end

    assign wake_evt = (wsync_q[1] == wsync_q[2]) && wsync_q[2] && !wfilt_q;

    // ----------------------------------------------------------------
    // Power state
    // ----------------------------------------------------------------
    logic sw_wake;

    assign sw_wake = take_wr && (address_i == REG_SLEEP) && writedata_i[SLP_WAKE];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_q <= PS_RUN;
        end else begin
            case (pwr_q)
                PS_RUN: begin
                    if (halt) begin
                        pwr_q <= PS_SLEEP;
                    end
                end
                PS_SLEEP: begin
                    if (wake_evt || wdog_to || sw_wake) begin
                        pwr_q <= PS_RUN;
                    end
                end
                default: begin
                    pwr_q <= PS_RUN;
                end
            endcase
        end
    end

    assign asleep_o  = (pwr_q == PS_SLEEP);
    assign osc_run_o = (pwr_q == PS_RUN);

    // ----------------------------------------------------------------
    // Accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= ACC_RESET;
        end else if (exec && op == OP_XORL) begin
            acc_q <= alu_res;
        end else if (exec && has_res && !dbit) begin
            acc_q <= alu_res;
        end else if (take_wr && address_i == REG_ACC) begin
            acc_q <= writedata_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // File registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (exec && has_res && dbit) begin
            file_q[fsel] <= alu_res;
        end else if (take_wr && address_i[FILE_SEL]) begin
            file_q[address_i[6:2]] <= writedata_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Direction register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_o <= DIR_RESET;
        end else if (exec && op == OP_DIR && fsel == DIR_OPERAND) begin
            dir_o <= acc_q;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            c_q  <= 1'b0;
            dc_q <= 1'b0;
            z_q  <= 1'b0;
        end else if (exec) begin
            if (upd_c) begin
                c_q <= alu_c;
            end
            if (upd_dc) begin
                dc_q <= alu_dc;
            end
            if (upd_z) begin
                z_q <= alu_z;
            end
        end else if (sw_wr_status) begin
            c_q  <= writedata_i[ST_C];
            dc_q <= writedata_i[ST_DC];
            z_q  <= writedata_i[ST_Z];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            to_n_q <= 1'b1;
            pwrdn_n_q <= 1'b1;
        end else if (halt) begin
            to_n_q <= 1'b1;
            pwrdn_n_q <= 1'b0;
        end else if (wdog_to) begin
            to_n_q <= 1'b0;
        end
    end

    // Set by a pin wake-up; a clear in the same cycle loses
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_flag_q <= 1'b0;
        end else if (wake_evt && pwr_q == PS_SLEEP) begin
            wake_flag_q <= 1'b1;
        end else if (sw_wr_status && !writedata_i[ST_WAKE]) begin
            wake_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (address_i[FILE_SEL]) begin
            rdata_d[7:0] = file_q[address_i[6:2]];
        end else begin
            case (address_i)
                REG_ACC:    rdata_d[7:0] = acc_q;
                REG_STATUS: begin
                    rdata_d[ST_C]    = c_q;
                    rdata_d[ST_DC]   = dc_q;
                    rdata_d[ST_Z]    = z_q;
                    rdata_d[ST_PWRDN_N] = pwrdn_n_q;
                    rdata_d[ST_TO_N] = to_n_q;
                    rdata_d[ST_WAKE] = wake_flag_q;
                end
                REG_DIR:    rdata_d[7:0] = dir_o;
                REG_WDOG:   rdata_d[15:0] = {wdog_pre, wdog_cnt};
                REG_SLEEP: begin
                    rdata_d[SLP_ASLEEP] = asleep_o;
                    rdata_d[SLP_OSC]    = osc_run_o;
                end
                default:    rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Captured at the waiting edge so data stands at the answering one
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (read_i && !ack_q) begin
            readdata_o <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_halt;
        halt;
    endsequence

    sequence s_halted;
        wdog_cnt == 8'h00 && wdog_pre == 8'h00 ##0 to_n_q && !pwrdn_n_q;
    endsequence

    property p_halt_wdog;
        s_halt |=> (wdog_cnt == 8'h00) && (wdog_pre == 8'h00);
    endproperty
    a_halt_wdog: assert property (p_halt_wdog) else $error("watchdog not cleared");

    property p_halt_flags;
        s_halt |=> s_halted ##0 (wake_flag_q == $past(wake_flag_q));
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt status wrong");

    property p_halt_sleep;
        s_halt |=> asleep_o && !osc_run_o;
    endproperty
    a_halt_sleep: assert property (p_halt_sleep) else $error("sleep not entered");

    property p_dest;
        exec && has_res && !dbit |=> acc_q == $past(alu_res) && $stable(file_q[$past(fsel)]);
    endproperty
    a_dest: assert property (p_dest) else $error("result not in accumulator");

    property p_rot_right;
        exec && op == OP_ROTR |=> c_q == $past(fval[0]) && $stable(z_q) && $stable(dc_q);
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("rotate right carry wrong");

    property p_rot_left;
        exec && op == OP_ROTL |=> c_q == $past(fval[7]) && $stable(z_q);
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left carry wrong");

    property p_sub;
        exec && op == OP_SUB |=> z_q == ($past(fval) == $past(acc_q))
            && c_q == ($past(fval) >= $past(acc_q));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract flags wrong");

    property p_swap;
        exec && op == OP_SWAP |=> $stable(c_q) && $stable(dc_q) && $stable(z_q);
    endproperty
    a_swap: assert property (p_swap) else $error("swap changed flags");

    property p_dir;
        exec && op == OP_DIR && fsel == DIR_OPERAND |=> dir_o == $past(acc_q) && $stable(z_q);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not loaded");

    property p_xor_file;
        exec && op == OP_XORF |=> z_q == (($past(acc_q) ^ $past(fval)) == 8'h00) && $stable(c_q);
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("xor file zero wrong");

    property p_xor_lit;
        exec && op == OP_XORL |=> acc_q == ($past(acc_q) ^ $past(lit));
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

endmodule : bcs_core
`default_nettype wire

/* File: hdl/bcs_pkg.sv */
// Purpose: Shared constants for the instruction subset execution block
// Assumes: Avalon-MM byte addresses, 32-bit data, registers one word apart
// Notes:   Opcode field encoding is local to this block
package bcs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_INSTR  = 8'h00;
    localparam logic [7:0] REG_ACC    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DIR    = 8'h0C;
    localparam logic [7:0] REG_WDOG   = 8'h10;
    localparam logic [7:0] REG_SLEEP  = 8'h14;
    localparam int         FILE_SEL   = 7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OP_MSB     = 15;
    localparam int OP_LSB     = 12;
    localparam int D_BIT      = 5;
    localparam int F_MSB      = 4;
    localparam int LIT_MSB    = 7;
    localparam int ST_C       = 0;
    localparam int ST_DC      = 1;
    localparam int ST_Z       = 2;
    localparam int ST_PWRDN_N = 3;
    localparam int ST_TO_N    = 4;
    localparam int ST_WAKE    = 7;
    localparam int SLP_ASLEEP = 0;
    localparam int SLP_WAKE   = 1;
    localparam int SLP_OSC    = 2;
    localparam int WDOG_PRE_LSB = 8;

    // ----------------------------------------------------------------
    // Values
    // ----------------------------------------------------------------
    localparam logic [4:0] DIR_OPERAND = 5'h06;
    localparam logic [7:0] DIR_RESET   = 8'hFF;
    localparam logic [7:0] ACC_RESET   = 8'h00;

    typedef enum logic [3:0] {
        OP_NOP    = 4'h0,
        OP_SLEEP  = 4'h1,
        OP_ROTL   = 4'h2,
        OP_ROTR   = 4'h3,
        OP_SUB    = 4'h4,
        OP_SWAP   = 4'h5,
        OP_DIR    = 4'h6,
        OP_XORL   = 4'h7,
        OP_XORF   = 4'h8
    } bcs_op_e;

    typedef enum logic [0:0] {
        PS_RUN   = 1'b0,
        PS_SLEEP = 1'b1
    } bcs_pwr_e;

endpackage : bcs_pkg

/* File: hdl/bcs_wdog.sv */
// Purpose: Watchdog counter with prescaler, cleared on request
// Assumes: Counts on every core clock
// Notes:   Clear wins over counting in the same cycle
`timescale 1ns/1ps
`default_nettype none
module bcs_wdog #(
    parameter int PRE_W = 8,
    parameter int CNT_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             clr_i,
    output logic      [PRE_W-1:0] pre_o,
    output logic      [CNT_W-1:0] cnt_o,
    output logic                  timeout_o
);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_o     <= '0;
            cnt_o     <= '0;
            timeout_o <= 1'b0;
        end else if (clr_i) begin
            pre_o     <= '0;
            cnt_o     <= '0;
            timeout_o <= 1'b0;
        end else begin
            pre_o     <= pre_o + 1'b1;
            timeout_o <= 1'b0;
            if (&pre_o) begin
                cnt_o     <= cnt_o + 1'b1;
                timeout_o <= &cnt_o;
            end
        end
    end

endmodule : bcs_wdog
`default_nettype wire

/* File: hdl/bcs_alu.sv */
// Purpose: Result and flag logic for the executed operation
// Assumes: Purely combinational, operands stable for the cycle
// Notes:   upd_* say which flags the operation changes
`timescale 1ns/1ps
`default_nettype none
module bcs_alu
    import bcs_pkg::*;
(
    input  wire bcs_op_e       op_i,
    input  wire logic    [7:0] acc_i,
    input  wire logic    [7:0] file_i,
    input  wire logic    [7:0] lit_i,
    input  wire logic          c_i,
    output logic         [7:0] res_o,
    output logic               c_o,
    output logic               dc_o,
    output logic               z_o,
    output logic               upd_c_o,
    output logic               upd_dc_o,
    output logic               upd_z_o,
    output logic               has_res_o
);

    logic [8:0] diff;
    logic [4:0] ndiff;

    // Two's complement: f + ~w + 1, carry out is the inverted borrow
    assign diff  = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
    assign ndiff = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

    always_comb begin
        res_o     = 8'h00;
        c_o       = c_i;
        dc_o      = 1'b0;
        upd_c_o   = 1'b0;
        upd_dc_o  = 1'b0;
        upd_z_o   = 1'b0;
        has_res_o = 1'b0;
        case (op_i)
            OP_ROTL: begin
                res_o     = {file_i[6:0], c_i};
                c_o       = file_i[7];
                upd_c_o   = 1'b1;
                has_res_o = 1'b1;
            end
            OP_ROTR: begin
                res_o     = {c_i, file_i[7:1]};
                c_o       = file_i[0];
                upd_c_o   = 1'b1;
                has_res_o = 1'b1;
            end
            OP_SUB: begin
                res_o     = diff[7:0];
                c_o       = diff[8];
                dc_o      = ndiff[4];
                upd_c_o   = 1'b1;
                upd_dc_o  = 1'b1;
                upd_z_o   = 1'b1;
                has_res_o = 1'b1;
            end
            OP_SWAP: begin
                res_o     = {file_i[3:0], file_i[7:4]};
                has_res_o = 1'b1;
            end
            OP_XORF: begin
                res_o     = acc_i ^ file_i;
                upd_z_o   = 1'b1;
                has_res_o = 1'b1;
            end
            OP_XORL: begin
                res_o     = acc_i ^ lit_i;
                upd_z_o   = 1'b1;
            end
            default: begin
                res_o     = 8'h00;
            end
        endcase
    end

    assign z_o = (res_o == 8'h00);

endmodule : bcs_alu
`default_nettype wire

/* File: dv/tb_baseline_core_instr_subset.sv */
// Purpose: Self-checking bench for the instruction subset core
// Assumes: Slave latency unknown; master waits on waitrequest
// Notes:   Wake pin held low; wake comes from the sleep register
`timescale 1ns/1ps
`default_nettype none
module tb_baseline_core_instr_subset
    import bcs_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------
    localparam logic [3:0] rotate_left_carry_op  = 4'h2;
    localparam logic [3:0] rotate_right_carry_op = 4'h3;
    localparam logic [3:0] xor_literal_op        = 4'h7;
    localparam logic [3:0] xor_file_op           = 4'h8;
    localparam logic [7:0] wdog_addr             = 8'h10;

    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        read_i      = 1'b0;
    logic        write_i     = 1'b0;
    logic        wake_pin_i  = 1'b0;
    logic [7:0]  address_i   = 8'h00;
    logic [31:0] writedata_i = 32'h0000_0000;
    wire  [31:0] readdata_o;
    wire         waitrequest_o;
    wire  [7:0]  dir_o;
    wire         osc_run_o;
    wire         asleep_o;
    int          mismatches  = 0;
    int          checks      = 0;
    int          cycles      = 0;

    bcs_core i_bcs_core (
        .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .wake_pin_i(wake_pin_i), .dir_o(dir_o),
        .osc_run_o(osc_run_o), .asleep_o(asleep_o)
    );

    always #12.5 clk_i = ~clk_i;

    // Generous ceiling; the full run needs about eight hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    // Request held until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        address_i   <= a;
        writedata_i <= d;
        read_i      <= ~wr;
        write_i     <= wr;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        q = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_i);
    endtask : access

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask : wr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
                              input logic [31:0] e);
        logic [31:0] q;
        access(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : expect_reg

    function automatic logic [7:0] fa(input logic [4:0] f);
        return {1'b1, f, 2'b00};
    endfunction : fa

    task automatic fop(input logic [3:0] op, input logic d, input logic [4:0] f);
        wr(REG_INSTR, {16'h0000, op, 6'h00, d, f});
    endtask : fop

    task automatic lit(input logic [7:0] k);
        wr(REG_INSTR, {16'h0000, xor_literal_op, 4'h0, k});
    endtask : lit

    task close_out;
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk({24'h0, dir_o}, {24'h0, DIR_RESET});
        chk({30'h0, osc_run_o, asleep_o}, 32'h2);
        expect_reg(REG_STATUS, 32'h18, 32'h18);
    endtask : t_reset

    task automatic t_xor_literal;
        wr(REG_ACC, 32'h5A);
        lit(8'hFF);
        expect_reg(REG_ACC, 32'hFF, 32'hA5);
        expect_reg(REG_STATUS, 32'h4, 32'h0);
        lit(8'hA5);
        expect_reg(REG_ACC, 32'hFF, 32'h00);
        lit(8'h00);
        expect_reg(REG_STATUS, 32'h4, 32'h4);
    endtask : t_xor_literal

    task automatic t_xor_file;
        wr(REG_STATUS, 32'h3);
        wr(fa(5'd31), 32'h3C);
        wr(REG_ACC, 32'h0F);
        fop(xor_file_op, 1'b1, 5'd31);
        expect_reg(fa(5'd31), 32'hFF, 32'h33);
        expect_reg(REG_ACC, 32'hFF, 32'h0F);
        expect_reg(REG_STATUS, 32'h7, 32'h3);
        wr(REG_ACC, 32'h33);
        fop(xor_file_op, 1'b0, 5'd31);
        expect_reg(REG_ACC, 32'hFF, 32'h00);
        expect_reg(REG_STATUS, 32'h7, 32'h7);
    endtask : t_xor_file

    task automatic t_rotate;
        wr(REG_STATUS, 32'h5);
        wr(fa(5'd0), 32'h81);
        fop(rotate_left_carry_op, 1'b1, 5'd0);
        expect_reg(fa(5'd0), 32'hFF, 32'h03);
        expect_reg(REG_STATUS, 32'h7, 32'h5);
        wr(REG_STATUS, 32'h4);
        fop(rotate_right_carry_op, 1'b0, 5'd0);
        expect_reg(REG_ACC, 32'hFF, 32'h01);
        expect_reg(REG_STATUS, 32'h7, 32'h5);
        fop(rotate_left_carry_op, 1'b0, 5'd0);
        expect_reg(REG_ACC, 32'hFF, 32'h07);
        expect_reg(REG_STATUS, 32'h7, 32'h4);
    endtask : t_rotate

    task automatic t_subtract;
        logic [7:0] sf [3] = '{8'h10, 8'h05, 8'h22};
        logic [7:0] sa [3] = '{8'h05, 8'h10, 8'h22};
        logic [7:0] r;
        for (int i = 0; i < 3; i++) begin
            r = sf[i] - sa[i];
            wr(fa(5'd5), {24'h0, sf[i]});
            wr(REG_ACC, {24'h0, sa[i]});
            wr(REG_STATUS, 32'h0);
            fop(OP_SUB, i[0], 5'd5);
            expect_reg(i[0] ? fa(5'd5) : REG_ACC, 32'hFF, {24'h0, r});
            expect_reg(REG_STATUS, 32'h7, {29'h0, r == 8'h00,
                       sf[i][3:0] >= sa[i][3:0], sf[i] >= sa[i]});
        end
    endtask : t_subtract

    task automatic t_swap_dir;
        wr(REG_STATUS, 32'h7);
        wr(fa(5'd9), 32'h1E);
        fop(OP_SWAP, 1'b0, 5'd9);
        expect_reg(REG_ACC, 32'hFF, 32'hE1);
        fop(OP_SWAP, 1'b1, 5'd9);
        expect_reg(fa(5'd9), 32'hFF, 32'hE1);
        expect_reg(REG_STATUS, 32'h7, 32'h7);
        wr(REG_ACC, 32'h5C);
        fop(OP_DIR, 1'b0, 5'd7);
        chk({24'h0, dir_o}, 32'hFF);
        fop(OP_DIR, 1'b0, 5'd6);
        chk({24'h0, dir_o}, 32'h5C);
        expect_reg(REG_STATUS, 32'h7, 32'h7);
    endtask : t_swap_dir

    task automatic t_halt;
        logic [31:0] q;
        // Let the counter move off zero so the clear is visible
        repeat (600) @(posedge clk_i);
        access(1'b0, wdog_addr, 32'h0, q);
        chk({31'h0, q[7:0] != 8'h00}, 32'h1);
        wr(REG_INSTR, {16'h0000, OP_SLEEP, 12'h000});
        chk({30'h0, osc_run_o, asleep_o}, 32'h1);
        access(1'b0, wdog_addr, 32'h0, q);
        chk(q[7:0], 32'h00);
        chk({31'h0, q[15:8] < 8'h08}, 32'h1);
        expect_reg(REG_STATUS, 32'h98, 32'h10);
        wr(REG_SLEEP, 32'h2);
        chk({30'h0, osc_run_o, asleep_o}, 32'h2);
    endtask : t_halt

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_xor_literal();
        t_xor_file();
        t_rotate();
        t_subtract();
        t_swap_dir();
        t_halt();
        close_out();
    end
endmodule : tb_baseline_core_instr_subset
`default_nettype wire
